//--- serdes_cal_regs.vh
// serdes_cal_regs.vh: offsets, field positions, reset values and timing counts
// for the serial interface calibration and analog control register bank.
// assumes a 250 MHz register clock and word-aligned AXI4-Lite byte addresses.
`ifndef SERDES_CAL_REGS_VH
`define SERDES_CAL_REGS_VH

// ==========================================================================
// register indices (byte address = 4 * index)
`define IDX_CAL_CTRL        12'h42e
`define IDX_SPARE_FORCE     12'h42f
`define IDX_DELAY_CTRL      12'h430
`define IDX_ESD_COUNT       12'h442
`define IDX_IRQ_STATUS      12'h500
`define IDX_IRQ_MASK        12'h501

// ==========================================================================
// calibration control fields
`define CAL_WDOG_DIS_BIT    11
`define CAL_WDOG_SEL_HI     10
`define CAL_WDOG_SEL_LO     9
`define CAL_AVG_HI          8
`define CAL_AVG_LO          7
`define CAL_START_BIT       6
`define CAL_LOCK_BIT        5
`define CAL_RW_MASK         16'h0f9e
`define CAL_RESET           16'h0000

// ==========================================================================
// spare force, delay line and esd counter fields
`define SPARE_RW_MASK       16'hffff
`define SPARE_RESET         16'h0000
`define DLY_EN_BIT          12
`define DLY_TX_HI           11
`define DLY_TX_LO           8
`define DLY_RX_HI           7
`define DLY_RX_LO           4
`define DLY_RW_MASK         16'h7fff
`define DLY_RESET           16'h0960
`define ESD_CNT_HI          14
`define ESD_CNT_LO          9
`define ESD_RW_MASK         16'h81ff

// ==========================================================================
// interrupt bits: 0 cal done, 1 cal timeout, 2 esd event
`define IRQ_BITS            3

// ==========================================================================
// watchdog limits in ns and derived cycle counts at 4 ns per cycle
`define CLK_PERIOD_NS       4
`define WDOG_T0_NS          32000
`define WDOG_T1_NS          48000
`define WDOG_T2_NS          64000
`define WDOG_T3_NS          128000
// sized to the 16-bit watchdog counter so the limit decode drops no bits
`define WDOG_C0             16'h1f40
`define WDOG_C1             16'h2ee0
`define WDOG_C2             16'h3e80
`define WDOG_C3             16'h7d00

`endif

//--- sync2.v
// sync2.v: per-bit two flip-flop synchroniser for asynchronous inputs.
// assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ps

module sync2 #(
  parameter W = 4
) (
  input  wire         i_ref_clk,
  input  wire         i_srst,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  // ========================================================================
  // synchroniser stages
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      // first stage feeds only the second
      always @(posedge i_ref_clk) begin
        if (i_srst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= i_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[g] = sync_reg;
    end
  endgenerate

endmodule // sync2

//--- serdes_cal_ctrl.v
// serdes_cal_ctrl.v: calibration sequencer, force controls, delay-line codes
// and esd event counter behind an AXI4-Lite slave.
// assumes analog status pins are asynchronous and the calibration engine
// answers each offset-tune pass with a done level or pulse.
`timescale 1ns/1ps
`include "serdes_cal_regs.vh"

module serdes_cal_ctrl (
  input  wire        i_ref_clk,
  input  wire        i_srst,
  input  wire [13:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [13:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        i_rx_recovery_locked,
  input  wire        i_rx_word_sync_status,
  input  wire        i_tune_pass_done,
  input  wire        i_esd_event,
  input  wire        i_energy_force_en,
  input  wire        i_mode_int,
  input  wire        i_term_en_int,
  input  wire        i_out_en_int,
  input  wire        i_offset_tune_int,
  input  wire        i_energy_loss_int,
  input  wire        i_energy_detector_on_int,
  input  wire        i_sleep_on_int,
  output reg         o_tune_pass_start,
  output reg         o_cal_busy,
  output reg         o_cal_use_default,
  output reg         o_mode,
  output reg         o_term_en,
  output reg         o_out_en,
  output reg         o_offset_tune,
  output reg         o_energy_loss,
  output reg         o_energy_detector_on,
  output reg         o_sleep_on,
  output reg  [3:0]  o_tx_delay_code,
  output reg  [3:0]  o_rx_delay_code,
  output reg         o_delay_en,
  output reg         o_irq
);

  // ========================================================================
  // input synchronisers
  wire [3:0] st_sync;
  wire       ev_sync;
  sync2 #(.W(4)) u_sync_st (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_async   ({i_rx_recovery_locked, i_rx_word_sync_status, i_tune_pass_done,
                 i_energy_force_en}),
    .o_sync    (st_sync)
  );
  sync2 #(.W(1)) u_sync_ev (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_async   (i_esd_event),
    .o_sync    (ev_sync)
  );
  wire locked_s    = st_sync[3];
  wire word_sync_s = st_sync[2];
  wire pass_done_s = st_sync[1];
  wire force_en_s  = st_sync[0];
  wire esd_s       = ev_sync;

  // ========================================================================
  // registers
  reg [15:0] cal_reg;
  reg [15:0] spare_reg;
  reg [15:0] dly_reg;
  reg [15:0] esd_reg;
  reg [5:0]  esd_cnt_reg;
  reg [`IRQ_BITS-1:0] irq_stat_reg;
  reg [`IRQ_BITS-1:0] irq_mask_reg;
  reg        esd_q_reg;
  reg        done_q_reg;

  // ========================================================================
  // axi write channel: address and data latched in either order
  reg        aw_hold_reg;
  reg        w_hold_reg;
  reg [11:0] aw_idx_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  wire       wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_idx_reg    <= 12'h000;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx_reg    <= s_axi_awaddr[13:2];
        aw_hold_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_hold_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_idx_reg == `IDX_CAL_CTRL || aw_idx_reg == `IDX_SPARE_FORCE ||
            aw_idx_reg == `IDX_DELAY_CTRL || aw_idx_reg == `IDX_ESD_COUNT ||
            aw_idx_reg == `IDX_IRQ_STATUS || aw_idx_reg == `IDX_IRQ_MASK) begin
          s_axi_bresp <= 2'h0;
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // byte-lane merge of the low 16 bits; upper lanes hold no storage
  wire [15:0] wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [15:0] wval  = wdata_reg[15:0];
  wire wr_cal   = wr_fire && (aw_idx_reg == `IDX_CAL_CTRL);
  wire wr_spare = wr_fire && (aw_idx_reg == `IDX_SPARE_FORCE);
  wire wr_dly   = wr_fire && (aw_idx_reg == `IDX_DELAY_CTRL);
  wire wr_esd   = wr_fire && (aw_idx_reg == `IDX_ESD_COUNT);
  wire wr_ist   = wr_fire && (aw_idx_reg == `IDX_IRQ_STATUS) && wstrb_reg[0];
  wire wr_imsk  = wr_fire && (aw_idx_reg == `IDX_IRQ_MASK) && wstrb_reg[0];
  wire start_cmd = wr_cal && wmask[`CAL_START_BIT] && wval[`CAL_START_BIT];

  // ========================================================================
  // calibration sequencer
  localparam ST_IDLE = 2'h0;
  localparam ST_PASS = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_GAP  = 2'h3;
  reg [1:0]  state_reg;
  reg [3:0]  pass_cnt_reg;
  reg [15:0] wdog_reg;
  reg [15:0] wdog_lim;
  reg [3:0]  pass_total;
  wire       cal_done_ev;
  wire       cal_tmo_ev;
  wire       wdog_on = !cal_reg[`CAL_WDOG_DIS_BIT];

  // limit and repetition decode
  always @* begin
    case (cal_reg[`CAL_WDOG_SEL_HI:`CAL_WDOG_SEL_LO])
      2'h0:    wdog_lim = `WDOG_C0;
      2'h1:    wdog_lim = `WDOG_C1;
      2'h2:    wdog_lim = `WDOG_C2;
      default: wdog_lim = `WDOG_C3;
    endcase
    case (cal_reg[`CAL_AVG_HI:`CAL_AVG_LO])
      2'h0:    pass_total = 4'h1;
      2'h1:    pass_total = 4'h2;
      2'h2:    pass_total = 4'h4;
      default: pass_total = 4'h8;
    endcase
  end

  wire pass_rise = pass_done_s && !done_q_reg;
  wire wdog_exp  = (state_reg != ST_IDLE) && wdog_on && (wdog_reg >= wdog_lim - 16'h1);
  assign cal_tmo_ev  = wdog_exp;
  assign cal_done_ev = !wdog_exp && (state_reg == ST_WAIT) && pass_rise &&
                       (pass_cnt_reg == pass_total - 4'h1);

  // sequencer: one start pulse per averaging pass, watchdog across the whole run
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_reg         <= ST_IDLE;
      pass_cnt_reg      <= 4'h0;
      wdog_reg          <= 16'h0000;
      done_q_reg        <= 1'b0;
      o_tune_pass_start <= 1'b0;
      o_cal_busy        <= 1'b0;
      o_cal_use_default <= 1'b0;
    end else begin
      done_q_reg        <= pass_done_s;
      o_tune_pass_start <= 1'b0;
      if (state_reg != ST_IDLE) begin
        wdog_reg <= wdog_reg + 16'h1;
      end
      if (cal_tmo_ev) begin
        state_reg         <= ST_IDLE;
        o_cal_busy        <= 1'b0;
        o_cal_use_default <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (start_cmd) begin
              state_reg         <= ST_PASS;
              pass_cnt_reg      <= 4'h0;
              wdog_reg          <= 16'h0000;
              o_cal_busy        <= 1'b1;
              o_cal_use_default <= 1'b0;
            end
          end
          ST_PASS: begin
            o_tune_pass_start <= 1'b1;
            state_reg         <= ST_WAIT;
          end
          ST_WAIT: begin
            if (pass_rise) begin
              if (cal_done_ev) begin
                state_reg  <= ST_IDLE;
                o_cal_busy <= 1'b0;
              end else begin
                pass_cnt_reg <= pass_cnt_reg + 4'h1;
                state_reg    <= ST_GAP;
              end
            end
          end
          default: begin
            // wait for done to drop before the next pass
            if (!pass_done_s) begin
              state_reg <= ST_PASS;
            end
          end
        endcase
      end
    end
  end

  // ========================================================================
  // register storage
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      cal_reg   <= `CAL_RESET;
      spare_reg <= `SPARE_RESET;
      dly_reg   <= `DLY_RESET;
      esd_reg   <= 16'h0000;
    end else begin
      if (wr_cal) begin
        cal_reg <= (cal_reg & ~(wmask & `CAL_RW_MASK)) | (wval & wmask & `CAL_RW_MASK);
      end
      // start bit reads one while the run is pending, then self-clears
      cal_reg[`CAL_START_BIT] <= start_cmd | (o_cal_busy & cal_reg[`CAL_START_BIT]);
      if (wr_spare) begin
        spare_reg <= (spare_reg & ~wmask) | (wval & wmask);
      end
      if (wr_dly) begin
        dly_reg <= (dly_reg & ~(wmask & `DLY_RW_MASK)) | (wval & wmask & `DLY_RW_MASK);
      end
      if (wr_esd) begin
        esd_reg <= (esd_reg & ~(wmask & `ESD_RW_MASK)) | (wval & wmask & `ESD_RW_MASK);
      end
    end
  end

  // esd counter saturates so a burst never reads back as a small number
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      esd_cnt_reg <= 6'h00;
      esd_q_reg   <= 1'b0;
    end else begin
      esd_q_reg <= esd_s;
      if (esd_s && !esd_q_reg && esd_cnt_reg != 6'h3f) begin
        esd_cnt_reg <= esd_cnt_reg + 6'h01;
      end
    end
  end

  // ========================================================================
  // interrupts: set wins over write-one-to-clear
  wire [`IRQ_BITS-1:0] irq_set = {esd_s && !esd_q_reg, cal_tmo_ev, cal_done_ev};
  wire [`IRQ_BITS-1:0] irq_clr = wr_ist ? wval[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      irq_stat_reg <= {`IRQ_BITS{1'b0}};
      irq_mask_reg <= {`IRQ_BITS{1'b0}};
      o_irq        <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (wr_imsk) begin
        irq_mask_reg <= wval[`IRQ_BITS-1:0];
      end
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ========================================================================
  // analog control outputs
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_mode               <= 1'b0;
      o_term_en            <= 1'b0;
      o_out_en             <= 1'b0;
      o_offset_tune        <= 1'b0;
      o_energy_loss        <= 1'b0;
      o_energy_detector_on <= 1'b0;
      o_sleep_on           <= 1'b0;
      o_tx_delay_code      <= 4'h0;
      o_rx_delay_code      <= 4'h0;
      o_delay_en           <= 1'b0;
    end else begin
      // forced value is the force bit itself; no separate value field exists
      o_mode        <= cal_reg[4] | i_mode_int;
      o_term_en     <= cal_reg[3] | i_term_en_int;
      o_out_en      <= cal_reg[2] | i_out_en_int;
      o_offset_tune <= cal_reg[1] | i_offset_tune_int;
      o_energy_loss        <= force_en_s ? spare_reg[2] : i_energy_loss_int;
      o_energy_detector_on <= force_en_s ? spare_reg[1] : i_energy_detector_on_int;
      o_sleep_on           <= force_en_s ? spare_reg[0] : i_sleep_on_int;
      o_delay_en      <= dly_reg[`DLY_EN_BIT];
      o_tx_delay_code <= dly_reg[`DLY_EN_BIT] ? dly_reg[`DLY_TX_HI:`DLY_TX_LO] : 4'h0;
      o_rx_delay_code <= dly_reg[`DLY_EN_BIT] ? dly_reg[`DLY_RX_HI:`DLY_RX_LO] : 4'h0;
    end
  end

  // ========================================================================
  // axi read channel: one cycle from address to data
  reg [15:0] rd_val;
  reg        rd_ok;
  always @* begin
    rd_val = 16'h0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr[13:2] == `IDX_CAL_CTRL) begin
      rd_val = {cal_reg[15:6], locked_s, cal_reg[4:1], word_sync_s};
    end else if (s_axi_araddr[13:2] == `IDX_SPARE_FORCE) begin
      rd_val = spare_reg;
    end else if (s_axi_araddr[13:2] == `IDX_DELAY_CTRL) begin
      rd_val = dly_reg;
    end else if (s_axi_araddr[13:2] == `IDX_ESD_COUNT) begin
      rd_val = {esd_reg[15], esd_cnt_reg, esd_reg[8:0]};
    end else if (s_axi_araddr[13:2] == `IDX_IRQ_STATUS) begin
      rd_val = {13'h0000, irq_stat_reg};
    end else if (s_axi_araddr[13:2] == `IDX_IRQ_MASK) begin
      rd_val = {13'h0000, irq_mask_reg};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_val};
        s_axi_rresp   <= rd_ok ? 2'h0 : 2'h2;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // serdes_cal_ctrl

//--- serdes_cal_ctrl_chk.sv
// serdes_cal_ctrl_chk.sv: port-level timing checks for the calibration register bank.
// assumes it is bound to serdes_cal_ctrl and sees only that module's ports.
`timescale 1ns/1ps

module serdes_cal_ctrl_chk (
  input wire        i_ref_clk,
  input wire        i_srst,
  input wire        i_energy_force_en,
  input wire        i_sleep_on_int,
  input wire        o_tune_pass_start,
  input wire        o_cal_busy,
  input wire        o_cal_use_default,
  input wire        o_sleep_on,
  input wire [3:0]  o_tx_delay_code,
  input wire [3:0]  o_rx_delay_code,
  input wire        o_delay_en,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  // ==========================================================================
  // run length and pass count; cleared between runs so each run stands alone
  reg [16:0] busy_cnt;
  reg [3:0]  pass_cnt;
  always @(posedge i_ref_clk) begin
    if (i_srst || !o_cal_busy) begin
      busy_cnt <= 17'h0;
    end else begin
      busy_cnt <= busy_cnt + 17'h1;
    end
    if (i_srst) begin
      pass_cnt <= 4'h0;
    end else if (o_tune_pass_start) begin
      pass_cnt <= pass_cnt + 4'h1;
    end else if (!o_cal_busy) begin
      pass_cnt <= 4'h0;
    end
  end

  // tolerance of a few cycles covers the start and stop registers
  function automatic bit near(input [16:0] n, input int c);
    return (n + 8 >= c) && (n <= c + 8);
  endfunction

  // ==========================================================================
  // assertions
  property p_dly_gate;
    !o_delay_en |-> o_tx_delay_code == 4'h0 && o_rx_delay_code == 4'h0;
  endproperty
  a_dly_gate: assert property (p_dly_gate) else $error("delay code out while disabled");
  property p_dly_rst;
    $fell(i_srst) |-> !o_delay_en && o_tx_delay_code == 4'h0;
  endproperty
  a_dly_rst: assert property (p_dly_rst) else $error("delay enable set after reset");
  property p_pass_pulse;
    o_tune_pass_start |=> !o_tune_pass_start;
  endproperty
  a_pass_pulse: assert property (p_pass_pulse) else $error("pass start too long");
  property p_pass_in_busy;
    o_tune_pass_start |-> o_cal_busy;
  endproperty
  a_pass_in_busy: assert property (p_pass_in_busy) else $error("pass outside run");
  property p_pass_count;
    $fell(o_cal_busy) && !o_cal_use_default |-> pass_cnt inside {4'h1, 4'h2, 4'h4, 4'h8};
  endproperty
  a_pass_count: assert property (p_pass_count) else $error("bad pass count");
  property p_dflt_on_fall;
    $rose(o_cal_use_default) |-> $fell(o_cal_busy);
  endproperty
  a_dflt_on_fall: assert property (p_dflt_on_fall) else $error("default without abort");
  property p_wdog_len;
    $fell(o_cal_busy) && o_cal_use_default |->
      near(busy_cnt, 8000) || near(busy_cnt, 12000) || near(busy_cnt, 16000) ||
      near(busy_cnt, 32000);
  endproperty
  a_wdog_len: assert property (p_wdog_len) else $error("watchdog length off");
  property p_wdog_max;
    o_cal_busy |-> busy_cnt <= 17'd32010;
  endproperty
  a_wdog_max: assert property (p_wdog_max) else $error("run past longest limit");
  property p_unforced;
    (!i_energy_force_en && $stable(i_sleep_on_int)) [*5] |-> o_sleep_on == i_sleep_on_int;
  endproperty
  a_unforced: assert property (p_unforced) else $error("sleep forced while off");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data not held");
endmodule // serdes_cal_ctrl_chk

//--- test_serdes_cal_ctrl.sv
// test_serdes_cal_ctrl.sv: directed AXI4-Lite testbench for the calibration register bank.
// assumes serdes_cal_ctrl, its register header and the checker are compiled first.
`timescale 1ns/1ps
`include "serdes_cal_regs.vh"

module test_serdes_cal_ctrl;
  reg         i_ref_clk = 1'b0;
  reg         i_srst = 1'b1;
  reg  [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg         i_rx_recovery_locked = 1'b0, i_rx_word_sync_status = 1'b0, i_tune_pass_done = 1'b0;
  reg         i_esd_event = 1'b0, i_energy_force_en = 1'b0, i_mode_int = 1'b0;
  reg         i_term_en_int = 1'b0, i_out_en_int = 1'b0, i_offset_tune_int = 1'b0;
  reg         i_energy_loss_int = 1'b0, i_energy_detector_on_int = 1'b0, i_sleep_on_int = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        o_tune_pass_start, o_cal_busy, o_cal_use_default, o_mode, o_term_en, o_out_en;
  wire        o_offset_tune, o_energy_loss, o_energy_detector_on, o_sleep_on, o_delay_en, o_irq;
  wire [3:0]  o_tx_delay_code, o_rx_delay_code;
  int         n_mismatch = 0, samples_checked = 0, cyc = 0, n_pass = 0, p0, t;
  int         wd [4] = '{32000 / 4, 48000 / 4, 64000 / 4, 128000 / 4};
  reg  [1:0]  rsp;
  reg  [15:0] v;
  reg  [3:0]  dly = 4'h0;
  reg         resp_en = 1'b0, kick = 1'b0;

  serdes_cal_ctrl u_dut (.i_ref_clk, .i_srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .i_rx_recovery_locked, .i_rx_word_sync_status,
    .i_tune_pass_done, .i_esd_event, .i_energy_force_en, .i_mode_int, .i_term_en_int,
    .i_out_en_int, .i_offset_tune_int, .i_energy_loss_int, .i_energy_detector_on_int,
    .i_sleep_on_int, .o_tune_pass_start, .o_cal_busy, .o_cal_use_default, .o_mode, .o_term_en,
    .o_out_en, .o_offset_tune, .o_energy_loss, .o_energy_detector_on, .o_sleep_on,
    .o_tx_delay_code, .o_rx_delay_code, .o_delay_en, .o_irq);

  // ==========================================================================
  // clock, hang guard, and a tune engine that answers each pass after a delay
  initial begin
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  always @(posedge i_ref_clk) begin
    if ((o_tune_pass_start || kick) && resp_en) dly <= 4'h6;
    else if (dly != 4'h0) dly <= dly - 4'h1;
    i_tune_pass_done <= (dly != 4'h0) && (dly < 4'h4);
    if (o_tune_pass_start) n_pass <= n_pass + 1;
  end

  // ==========================================================================
  // bus tasks and comparisons
  task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic wr(input [11:0] idx, input [15:0] d);
    @(posedge i_ref_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input [11:0] idx, output [15:0] d);
    @(posedge i_ref_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata[15:0];
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input [11:0] idx, input [15:0] exp);
    reg [15:0] got;
    rd(idx, got);
    chk($sformatf("reg %h", idx), exp, got);
  endtask
  task automatic wait_idle;
    t = 0;
    do begin
      @(posedge i_ref_clk);
      t++;
    end while (o_cal_busy);
  endtask
  task automatic esd_hit;
    @(posedge i_ref_clk);
    i_esd_event <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_esd_event <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rchk(`IDX_CAL_CTRL, 16'h0000);
    rchk(`IDX_SPARE_FORCE, 16'h0000);
    rchk(`IDX_DELAY_CTRL, 16'h0960);
    rchk(`IDX_ESD_COUNT, 16'h0000);
    chk("delay out", 9'h0, {o_delay_en, o_tx_delay_code, o_rx_delay_code});
    wr(`IDX_DELAY_CTRL, 16'hfa50);
    rchk(`IDX_DELAY_CTRL, 16'h7a50);
    chk("delay out", 9'h1a5, {o_delay_en, o_tx_delay_code, o_rx_delay_code});
    rd(12'h7ff, v);
    chk("rresp", 2'b10, rsp);
    wr(12'h7ff, 16'h1234);
    chk("bresp", 2'b10, rsp);
    // esd counter is read-only beside its writable spare bits; irq masked then unmasked
    wr(`IDX_IRQ_MASK, 16'h0000);
    repeat (3) esd_hit;
    wr(`IDX_ESD_COUNT, 16'hffff);
    rchk(`IDX_ESD_COUNT, 16'h87ff);
    rd(`IDX_IRQ_STATUS, v);
    chk("esd flag", 16'h0004, v & 16'h0004);
    chk("irq masked", 1'b0, o_irq);
    wr(`IDX_IRQ_MASK, 16'h0004);
    repeat (2) @(posedge i_ref_clk);
    chk("irq on", 1'b1, o_irq);
    wr(`IDX_IRQ_STATUS, 16'h0004);
    repeat (2) @(posedge i_ref_clk);
    chk("irq off", 1'b0, o_irq);
    wr(`IDX_IRQ_MASK, 16'h0007);
    // force bits and live status bits
    wr(`IDX_CAL_CTRL, 16'h001e);
    repeat (3) @(posedge i_ref_clk);
    chk("forced", 4'hf, {o_mode, o_term_en, o_out_en, o_offset_tune});
    wr(`IDX_CAL_CTRL, 16'h0004);
    i_rx_recovery_locked <= 1'b1;
    i_rx_word_sync_status <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    chk("forced", 4'h2, {o_mode, o_term_en, o_out_en, o_offset_tune});
    rchk(`IDX_CAL_CTRL, 16'h0025);
    i_rx_recovery_locked <= 1'b0;
    i_rx_word_sync_status <= 1'b0;
    wr(`IDX_CAL_CTRL, 16'h0000);
    // energy and sleep values follow the external force enable
    i_energy_detector_on_int <= 1'b1;
    wr(`IDX_SPARE_FORCE, 16'h0005);
    repeat (5) @(posedge i_ref_clk);
    chk("unforced", 3'b010, {o_energy_loss, o_energy_detector_on, o_sleep_on});
    i_energy_force_en <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    chk("forced", 3'b101, {o_energy_loss, o_energy_detector_on, o_sleep_on});
    i_energy_force_en <= 1'b0;
    // averaging: every code, with the start bit reading back clear
    resp_en <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      p0 = n_pass;
      wr(`IDX_CAL_CTRL, {7'h00, a[1:0], 7'h40});
      wait_idle;
      chk("passes", 1 << a, n_pass - p0);
      chk("no default", 1'b0, o_cal_use_default);
      rchk(`IDX_CAL_CTRL, {7'h00, a[1:0], 7'h00});
    end
    // watchdog: an engine that never answers, every limit code
    resp_en <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      wr(`IDX_CAL_CTRL, {5'h00, s[1:0], 9'h040});
      wait_idle;
      chk("default", 1'b1, o_cal_use_default);
      chk("limit", 1'b1, (t + 8 >= wd[s]) && (t <= wd[s] + 8));
    end
    rd(`IDX_IRQ_STATUS, v);
    chk("timeout flag", 16'h0002, v & 16'h0002);
    chk("irq", 1'b1, o_irq);
    // disabled watchdog outlasts the shortest limit, then finishes normally
    wr(`IDX_CAL_CTRL, 16'h0840);
    repeat (8500) @(posedge i_ref_clk);
    chk("still busy", 1'b1, o_cal_busy);
    resp_en <= 1'b1;
    kick <= 1'b1;
    @(posedge i_ref_clk);
    kick <= 1'b0;
    wait_idle;
    chk("no default", 1'b0, o_cal_use_default);
    wrap_up;
  end
endmodule // test_serdes_cal_ctrl

bind serdes_cal_ctrl serdes_cal_ctrl_chk u_chk (.i_ref_clk, .i_srst, .i_energy_force_en,
  .i_sleep_on_int, .o_tune_pass_start, .o_cal_busy, .o_cal_use_default, .o_sleep_on,
  .o_tx_delay_code, .o_rx_delay_code, .o_delay_en, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
